/* File: hw/port_a_regs_pkg.sv */
/*
  Constants for the port A control/status register bank: register indexes,
  field positions, reset values and the operating-mode reset code.
  Assumes a byte-wide register space reached through a 32-bit Wishbone slave.
*/
package port_a_regs_pkg;

  // Printed offsets are indexes; byte address is four times the index
  localparam logic [5:0] IDX_CTRL2 = 6'h05;
  localparam logic [5:0] IDX_STATUS = 6'h06;
  localparam logic [5:0] IDX_CNT_LOW = 6'h07;
  localparam logic [5:0] IDX_CNT_MID = 6'h08;
  localparam logic [5:0] IDX_CNT_HIGH = 6'h09;

  // Second control register fields
  localparam int BIT_WIDTH16 = 7;
  localparam int BIT_UPPER_SINGLE = 6;
  localparam int BIT_RESERVED = 5;
  localparam int BIT_DISABLE = 4;
  localparam int BIT_CLR_IFACE = 3;
  localparam int BIT_CLR_COUNT = 2;
  localparam int BIT_PAR_EN = 1;
  localparam int BIT_PAR_ODD = 0;

  // Status register fields
  localparam int BIT_LOW_ONLY = 6;
  localparam int POS_EOR_COUNT = 4;
  localparam int POS_IFACE_COUNT = 0;

  // Values after reset
  localparam logic [23:0] COUNT_RESET = 24'h000000;
  localparam logic [2:0] MODE_RESET_CODE = 3'h0;
  localparam logic [31:0] READ_ZERO = 32'h00000000;

endpackage : port_a_regs_pkg

/* File: hw/pin_sync3.sv */
/*
  Three-flop synchroniser for a pin level; change accepted when the last two
  stages agree. Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync3
(
  input wire logic ref_clk, // Chip clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic pin, // Asynchronous pin level
  output logic level // Filtered level
);
  logic [2:0] stage;
  logic [2:0] next_stage;
  logic next_level;

  // Only stage[2:1] are compared; stage[0] feeds stage[1] alone
  always_comb
  begin
    next_stage = {stage[1:0], pin};
    next_level = (stage[2] == stage[1]) ? stage[2] : level;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      stage <= 3'h0;
      level <= 1'b0;
    end
    else
    begin
      stage <= next_stage;
      level <= next_level;
    end
  end
endmodule // pin_sync3
`default_nettype wire

/* File: hw/lane_parity.sv */
/*
  Parity generator for one byte lane. Assumes the caller gates the result
  by lane use and enable.
*/
`timescale 1ns/1ps
`default_nettype none
module lane_parity
#(
  parameter int WIDTH = 8
)
(
  input wire logic [WIDTH-1:0] data, // Lane data
  input wire logic odd, // One selects odd parity
  output logic par // Parity bit
);
  // Odd parity makes the total count of ones odd
  assign par = (^data) ^ odd;
endmodule // lane_parity
`default_nettype wire

/* File: hw/port_a_ctrl_status.sv */
/*
  Port A second control register, status register and 24-bit byte counter,
  with the pin-side gating these bits steer (width, parity, disable, ack).
  Assumes the port DMA engine supplies byte/EOR counts of the port interface,
  a last-byte indication and the operating-mode field; classic Wishbone host.
*/
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Width bit one uses all sixteen data pins; zero uses lower eight.
// - Width and parity bits are undefined after reset; software initialises.
// - Upper-lane single byte moves one byte on high lane, sixteen-bit only.
// - Next DMA cycle is next acknowledge pulse; bit clears after it.
// - Reset pin clears the upper-lane single-byte bit.
// - Reserved bit five reads zero; software writes zero.
// - Disable tristates port outputs and ignores port inputs.
// - Writing one to clear-interface pulses once; bit reads zero.
// - Writing one to clear-counter zeroes byte counter; bit reads zero.
// - Parity uses both pins in sixteen-bit mode, pin zero in eight.
// - Parity-sense one selects odd parity, zero selects even.
// - Last lone output byte goes on low lane and sets low-only flag.
// - Low-only flag clears on input cycles, eight-bit cycles and reset.
// - End-record count reports flagged bytes; clears on clear, mode reset.
// - Interface byte count reports held bytes; clears on clear, mode reset.
// - 24-bit counter in three byte registers counts every port byte.
// - Counter wraps to zero; cleared by clear pulse or reset.
// - Acknowledge polarity bit one means active high, zero active low.
module port_a_ctrl_status
  import port_a_regs_pkg::*;
(
  input wire logic ref_clk, // 40 MHz chip clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte selects
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  output logic wb_err_o, // Unmapped address
  input wire logic [2:0] operating_mode_field, // Main mode field
  input wire logic ack_polarity, // One: acknowledge active high
  input wire logic port_dma_acknowledge, // Acknowledge pin level
  input wire logic dir_out, // One: DMA cycle out of port
  input wire logic last_byte_lone, // Final byte of final record starts a word
  input wire logic [3:0] iface_bytes, // Bytes held in port interface
  input wire logic [1:0] iface_eor, // Flagged bytes in port interface
  input wire logic [15:0] out_data, // Data from interface to pins
  input wire logic [15:0] port_data_pins_i, // Data pins in
  output logic [15:0] port_data_pins_o, // Data pins out
  output logic [15:0] port_data_pins_oe, // Data pin enables
  input wire logic [1:0] port_parity_pins_i, // Parity pins in
  output logic [1:0] port_parity_pins_o, // Parity pins out
  output logic [1:0] port_parity_pins_oe, // Parity pin enables
  output logic ctrl_out_enable, // Gate for port output control pins
  output logic [15:0] in_data, // Captured input data
  output logic [1:0] in_parity_err, // Parity error per lane
  output logic dma_cycle, // Accepted acknowledge pulse
  output logic [1:0] lane_valid, // Lanes carrying a byte this cycle
  output logic clear_iface // Pulse emptying port interface
);

  // Control state
  logic width16, upper_single, port_off, par_en, par_odd;
  logic next_width16, next_upper_single, next_port_off, next_par_en, next_par_odd;
  logic next_clear_iface, clear_count, next_clear_count;
  logic low_only, next_low_only;
  logic [23:0] count, next_count;
  logic [3:0] iface_count;
  logic [1:0] eor_count;
  logic ack_sync, ack_prev, next_ack_prev, ack_active;
  logic [15:0] next_in_data;
  logic [1:0] next_in_parity_err;
  logic [1:0] par_gen, par_chk;
  logic wb_req, wb_hit, wr_en, next_ack, next_err;
  logic [5:0] idx;
  logic [7:0] rd_byte;
  logic [31:0] next_dat;
  logic mode_reset;

  assign idx = wb_adr_i[7:2];
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign wb_hit = (idx >= IDX_CTRL2) && (idx <= IDX_CNT_HIGH);
  // Write lands at the edge where the master samples ack high
  assign wr_en = wb_cyc_i & wb_stb_i & wb_ack_o & wb_hit & wb_we_i & wb_sel_i[0];
  assign mode_reset = (operating_mode_field == MODE_RESET_CODE);

  // Acknowledge pin is asynchronous; polarity applied after sync
  pin_sync3 ack_sync_i
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin(port_dma_acknowledge),
    .level(ack_sync)
  );
  assign ack_active = (ack_sync == ack_polarity) & ~port_off;
  // A DMA cycle is counted at the end of each active pulse
  assign dma_cycle = ack_prev & ~ack_active;

  // Lanes in use this cycle
  always_comb
  begin
    if (!width16)
      lane_valid = 2'b01;
    else if (upper_single)
      lane_valid = 2'b10;
    else if (dir_out && last_byte_lone)
      lane_valid = 2'b01;
    else
      lane_valid = 2'b11;
  end

  // Parity per lane
  for (genvar g = 0; g < 2; g++)
  begin : g_par
    lane_parity #(.WIDTH(8)) par_i
    (
      .data(port_data_pins_o[g*8 +: 8]),
      .odd(par_odd),
      .par(par_gen[g])
    );
    lane_parity #(.WIDTH(8)) chk_i
    (
      .data(port_data_pins_i[g*8 +: 8]),
      .odd(par_odd),
      .par(par_chk[g])
    );
  end

  // Pin drive; disable tristates everything, high lane unused in 8-bit
  always_comb
  begin
    port_data_pins_o = out_data;
    if (width16 && upper_single)
      port_data_pins_o = {out_data[7:0], 8'h00};
    port_data_pins_oe = 16'h0000;
    port_parity_pins_oe = 2'b00;
    if (!port_off && dir_out && ack_active)
    begin
      port_data_pins_oe = {{8{lane_valid[1]}}, {8{lane_valid[0]}}};
      if (par_en)
        port_parity_pins_oe = width16 ? 2'b11 : 2'b01;
    end
    port_parity_pins_o = par_gen;
  end
  assign ctrl_out_enable = ~port_off;

  // Input capture ignored while disabled
  always_comb
  begin
    next_in_data = in_data;
    next_in_parity_err = in_parity_err;
    if (ack_active && !dir_out && !port_off)
    begin
      next_in_data = width16 ? port_data_pins_i : {8'h00, port_data_pins_i[7:0]};
      next_in_parity_err = 2'b00;
      if (par_en)
        next_in_parity_err = (par_chk ^ port_parity_pins_i) & (width16 ? 2'b11 : 2'b01);
    end
  end

  // Interface counts mirrored and cleared on pulse or mode reset
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || clear_iface || mode_reset)
    begin
      iface_count <= 4'h0;
      eor_count <= 2'h0;
    end
    else
    begin
      iface_count <= iface_bytes;
      eor_count <= iface_eor;
    end
  end

  // Control register, pulses, low-only flag, counter
  always_comb
  begin
    next_width16 = width16;
    next_upper_single = upper_single;
    next_port_off = port_off;
    next_par_en = par_en;
    next_par_odd = par_odd;
    next_clear_iface = 1'b0;
    next_clear_count = 1'b0;
    next_low_only = low_only;
    next_count = count;
    next_ack_prev = ack_active;
    if (dma_cycle)
    begin
      next_upper_single = 1'b0;
      if (!width16 || !dir_out)
        next_low_only = 1'b0;
      else
        next_low_only = (lane_valid == 2'b01);
      next_count = count + ((lane_valid == 2'b11) ? 24'h000002 : 24'h000001);
    end
    if (!width16)
      next_low_only = 1'b0;
    if (wr_en && idx == IDX_CTRL2)
    begin
      next_width16 = wb_dat_i[BIT_WIDTH16];
      next_upper_single = wb_dat_i[BIT_UPPER_SINGLE] & wb_dat_i[BIT_WIDTH16];
      next_port_off = wb_dat_i[BIT_DISABLE];
      next_clear_iface = wb_dat_i[BIT_CLR_IFACE];
      next_clear_count = wb_dat_i[BIT_CLR_COUNT];
      next_par_en = wb_dat_i[BIT_PAR_EN];
      next_par_odd = wb_dat_i[BIT_PAR_ODD];
    end
    if (wr_en && idx == IDX_CNT_LOW)
      next_count[7:0] = wb_dat_i[7:0];
    if (wr_en && idx == IDX_CNT_MID)
      next_count[15:8] = wb_dat_i[7:0];
    if (wr_en && idx == IDX_CNT_HIGH)
      next_count[23:16] = wb_dat_i[7:0];
    if (clear_count)
      next_count = COUNT_RESET;
  end

  // Width and parity bits keep no reset: undefined by design
  always_ff @(posedge ref_clk)
  begin
    width16 <= next_width16;
    par_en <= next_par_en;
    par_odd <= next_par_odd;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      upper_single <= 1'b0;
      port_off <= 1'b0;
      clear_iface <= 1'b0;
      clear_count <= 1'b0;
      low_only <= 1'b0;
      count <= COUNT_RESET;
      ack_prev <= 1'b0;
      in_data <= 16'h0000;
      in_parity_err <= 2'b00;
    end
    else
    begin
      upper_single <= next_upper_single;
      port_off <= next_port_off;
      clear_iface <= next_clear_iface;
      clear_count <= next_clear_count;
      low_only <= next_low_only;
      count <= next_count;
      ack_prev <= next_ack_prev;
      in_data <= next_in_data;
      in_parity_err <= next_in_parity_err;
    end
  end

  // Read mux; pulse bits and reserved bits read zero
  always_comb
  begin
    rd_byte = 8'h00;
    unique case (idx)
      IDX_CTRL2: rd_byte = {width16, upper_single, 1'b0, port_off, 2'b00, par_en, par_odd};
      IDX_STATUS: rd_byte = {1'b0, low_only, eor_count, iface_count};
      IDX_CNT_LOW: rd_byte = count[7:0];
      IDX_CNT_MID: rd_byte = count[15:8];
      IDX_CNT_HIGH: rd_byte = count[23:16];
      default: rd_byte = 8'h00;
    endcase
    next_ack = wb_req & wb_hit;
    next_err = wb_req & ~wb_hit;
    next_dat = wb_req ? {24'h000000, rd_byte} : READ_ZERO;
  end

  // Registered answer: one wait state, ack drops the cycle after
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= READ_ZERO;
    end
    else
    begin
      wb_ack_o <= next_ack;
      wb_err_o <= next_err;
      wb_dat_o <= next_dat;
    end
  end

  clear_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clear_iface |=> !clear_iface) else $error("clear pulse longer than one cycle");
  single_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    dma_cycle |=> !upper_single || $past(wr_en)) else $error("single-byte bit not cleared");
  count_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clear_count |=> count == 24'h000000) else $error("counter not zeroed");
  count_step_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    dma_cycle && !clear_count && !wr_en && lane_valid == 2'b11 |=> count == $past(count) + 24'h000002)
    else $error("counter did not add two");
  disable_float_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    port_off |-> port_data_pins_oe == 16'h0000 && port_parity_pins_oe == 2'b00)
    else $error("pins driven while disabled");
  narrow_lane_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !width16 |-> port_data_pins_oe[15:8] == 8'h00 && port_parity_pins_oe[1] == 1'b0)
    else $error("high lane driven in 8-bit mode");
  low_only_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !width16 |=> !low_only) else $error("low-only flag set in 8-bit mode");
  status_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clear_iface |=> iface_count == 4'h0 && eor_count == 2'h0) else $error("counts not cleared");
  parity_pins_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    par_en && width16 && dir_out && ack_active |-> port_parity_pins_oe == 2'b11)
    else $error("parity pins not driven in 16-bit mode");
  bus_ack_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
endmodule // port_a_ctrl_status
`default_nettype wire

/* File: dv/dma_peer.sv */
/*
  Model of the DMA peer on port A: pulses the acknowledge pin and offers
  data and parity on the pins. Assumes the bench resolves pin levels.
*/
`timescale 1ns/1ps
`default_nettype none
module dma_peer
(
  input wire logic ref_clk, // Chip clock
  input wire logic polarity, // One: acknowledge active high
  input wire logic go, // Start one acknowledge pulse
  input wire logic [3:0] hold, // Active cycles, sets the pace
  input wire logic [15:0] data, // Data to offer in input cycles
  output logic ack_pin, // Acknowledge pin level
  output logic [15:0] data_pin, // Data toward the block
  output logic [1:0] par_pin, // Parity toward the block
  output logic busy // Pulse or recovery in progress
);
  logic [4:0] cnt = 5'h00;
  // Idle tail of six cycles outlasts the block's three-flop synchroniser
  always_ff @(posedge ref_clk)
  begin
    if (go)
      cnt <= {1'b0, hold} + 5'h06;
    else if (cnt != 5'h00)
      cnt <= cnt - 5'h01;
  end
  assign busy = go || (cnt != 5'h00);
  assign ack_pin = (cnt > 5'h06) ? polarity : ~polarity;
  // Outside the pulse the lines carry the inverted data, so stale data never looks valid
  assign data_pin = (cnt > 5'h06) ? data : ~data;
  assign par_pin = {~^data_pin[15:8], ~^data_pin[7:0]};
endmodule // dma_peer
`default_nettype wire

/* File: dv/testbench.sv */
/*
  Self-checking bench for the port A control/status bank: Wishbone register
  tasks plus a DMA peer model. Assumes the engine inputs are driven here.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import port_a_regs_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, err, last_err;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h00000000, rdat;
  logic [2:0] mode = 3'h0;
  logic pol = 1'b1, go = 1'b0, busy, dir_out = 1'b0, lone = 1'b0, ack_pin;
  logic [3:0] hold = 4'h3, iface_bytes = 4'h0;
  logic [1:0] iface_eor = 2'h0, par_o, par_oe, peer_par;
  logic [15:0] out_data = 16'h0000, pins_o, pins_oe, peer_data;
  logic ctrl_oe, clear_iface;
  int mismatches = 0, n_compared = 0, cycles = 0, n_clear = 0;

  // Clock at 40 MHz
  always #12.5 ref_clk = ~ref_clk;

  port_a_ctrl_status dut
  (
    .ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(err), .operating_mode_field(mode), .ack_polarity(pol),
    .port_dma_acknowledge(ack_pin), .dir_out(dir_out), .last_byte_lone(lone),
    .iface_bytes(iface_bytes), .iface_eor(iface_eor), .out_data(out_data),
    .port_data_pins_i((pins_oe & pins_o) | (~pins_oe & peer_data)),
    .port_data_pins_o(pins_o), .port_data_pins_oe(pins_oe),
    .port_parity_pins_i((par_oe & par_o) | (~par_oe & peer_par)),
    .port_parity_pins_o(par_o), .port_parity_pins_oe(par_oe),
    .ctrl_out_enable(ctrl_oe), .in_data(), .in_parity_err(), .dma_cycle(),
    .lane_valid(), .clear_iface(clear_iface)
  );

  dma_peer peer
  (
    .ref_clk(ref_clk), .polarity(pol), .go(go), .hold(hold), .data(16'h5AC3),
    .ack_pin(ack_pin), .data_pin(peer_data), .par_pin(peer_par), .busy(busy)
  );

  // Clear pulses seen, and the hang guard
  always @(posedge ref_clk)
  begin
    cycles++;
    if (clear_iface === 1'b1)
      n_clear++;
    if (cycles == 5000)
    begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Classic single cycle; held until ack or err is sampled high
  task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] d,
                    output logic [7:0] q);
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h000000, d};
    do @(posedge ref_clk); while (!(ack === 1'b1 || err === 1'b1));
    q = rdat[7:0];
    last_err = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    // Let the write applied at the ack edge settle before callers look
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, idx, d, q);
  endtask

  // Mask hides bits left undefined by reset
  task automatic rd(input logic [5:0] idx, input logic [7:0] exp, input logic [7:0] m,
                    input string what);
    logic [7:0] q;
    wb(1'b0, idx, 8'h00, q);
    chk(what, {16'h0000, exp}, {16'h0000, q & m});
  endtask

  task automatic cnt(input logic [23:0] exp);
    rd(IDX_CNT_LOW, exp[7:0], 8'hFF, "count_low");
    rd(IDX_CNT_MID, exp[15:8], 8'hFF, "count_mid");
    rd(IDX_CNT_HIGH, exp[23:16], 8'hFF, "count_high");
  endtask

  // One acknowledge pulse, then wait out the peer's recovery
  task automatic dma(input logic last);
    lone <= last;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    @(posedge ref_clk);
    while (busy) @(posedge ref_clk);
    repeat (2) @(posedge ref_clk);
    lone <= 1'b0;
  endtask

  initial
  begin
    logic [7:0] q;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(IDX_CTRL2, 8'h00, 8'h7C, "ctrl_after_reset");
    rd(IDX_STATUS, 8'h00, 8'hFF, "status_after_reset");
    cnt(24'h000000);
    wb(1'b0, 6'h0A, 8'h00, q);
    chk("unmapped_err", 24'h000001, {23'h0, last_err});
    mode <= MODE_RESET_CODE;
    wr(IDX_CTRL2, 8'h83);
    rd(IDX_CTRL2, 8'h83, 8'hFF, "ctrl_width16");
    repeat (3) dma(1'b0);
    cnt(24'h000006);
    hold <= 4'h8;
    wr(IDX_CTRL2, 8'hC3);
    rd(IDX_CTRL2, 8'hC3, 8'hFF, "ctrl_single");
    dma(1'b0);
    cnt(24'h000007);
    rd(IDX_CTRL2, 8'h83, 8'hFF, "single_cleared");
    wr(IDX_CTRL2, 8'h43);
    rd(IDX_CTRL2, 8'h03, 8'hFF, "ctrl_width8");
    dma(1'b0);
    cnt(24'h000008);
    // Disabled port ignores the polarity flip and the pulse
    wr(IDX_CTRL2, 8'h93);
    chk("ctrl_out_enable", 24'h000000, {23'h0, ctrl_oe});
    chk("data_oe_disabled", 24'h000000, {8'h00, pins_oe});
    pol <= 1'b0;
    dma(1'b0);
    cnt(24'h000008);
    wr(IDX_CTRL2, 8'h83);
    dma(1'b0);
    cnt(24'h00000A);
    wr(IDX_CTRL2, 8'h87);
    cnt(24'h000000);
    rd(IDX_CTRL2, 8'h83, 8'hFF, "clear_count_reads_zero");
    wr(IDX_CNT_LOW, 8'hFF);
    wr(IDX_CNT_MID, 8'hFF);
    wr(IDX_CNT_HIGH, 8'hFF);
    wr(IDX_CTRL2, 8'h03);
    dma(1'b0);
    cnt(24'h000000);
    mode <= 3'h1;
    iface_bytes <= 4'h9;
    iface_eor <= 2'h2;
    rd(IDX_STATUS, 8'h29, 8'hFF, "status_counts");
    wr(IDX_CTRL2, 8'h0B);
    rd(IDX_CTRL2, 8'h03, 8'hFF, "clear_iface_reads_zero");
    chk("clear_pulses", 24'h000001, n_clear[23:0]);
    mode <= MODE_RESET_CODE;
    rd(IDX_STATUS, 8'h00, 8'hFF, "status_mode_reset");
    // Output lanes and parity, both senses and both widths
    dir_out <= 1'b1;
    out_data <= 16'hA53C;
    wr(IDX_CTRL2, 8'h83);
    chk("data_out", 24'h00A53C, {8'h00, pins_o});
    chk("parity_odd", 24'h000003, {22'h0, par_o});
    chk("parity_oe_idle", 24'h000000, {22'h0, par_oe});
    wr(IDX_CTRL2, 8'h82);
    chk("parity_even", 24'h000000, {22'h0, par_o});
    wr(IDX_CTRL2, 8'h03);
    chk("data_oe_idle", 24'h000000, {8'h00, pins_oe});
    chk("parity_oe8_idle", 24'h000000, {22'h0, par_oe});
    wr(IDX_CTRL2, 8'h83);
    dma(1'b1);
    rd(IDX_STATUS, 8'h40, 8'hFF, "low_only_set");
    dir_out <= 1'b0;
    dma(1'b0);
    rd(IDX_STATUS, 8'h00, 8'hFF, "low_only_cleared");
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
